// *** logic/spc_top.v ***
// standby power commands and automatic power-down timer
`timescale 1ns/1ps
`include "spc_defs.vh"

module spc_top #(
    parameter [`SPC_TICK_W-1:0] TICK_CYCLES = `SPC_TICK_CYCLES
) (
    // clock and reset
    input  wire       clk_in,
    input  wire       rstn_in,
    // command register interface
    input  wire       cmd_valid_in,
    input  wire [7:0] cmd_opcode_in,
    input  wire [7:0] cmd_count_in,
    input  wire       host_access_in,
    input  wire       epc_enable_in,
    // spindle motor control
    input  wire       spindle_at_speed_in,
    input  wire       spindle_stopped_in,
    output reg        spindle_run_out,
    // power state
    output reg        standby_out,
    output reg        standby_z_out,
    output reg        host_hold_out,
    output reg        timer_enabled_out,
    // command completion and result registers
    output reg        cmd_done_out,
    output reg  [7:0] command_error_flags,
    output reg  [7:0] device_status_flags
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [1:0] ST_IDLE     = 2'b00;
    localparam [1:0] ST_SPINDOWN = 2'b01;
    localparam [1:0] ST_STANDBY  = 2'b10;
    localparam [1:0] ST_SPINUP   = 2'b11;
    // idle: motor at speed, the countdown may run
    // spin-down: motor request dropped, commands refused until rest
    // standby: motor at rest, commands taken, most of them wake the drive
    // spin-up: motor request raised, commands held until it is at speed

    // ----------------------------------------------------------------
    // timeout decode
    // ----------------------------------------------------------------
    function [`SPC_SECS_W-1:0] spc_secs;
        input [7:0] code;
        reg   [`SPC_SECS_W-1:0] wide;
        begin
            wide = {7'h00, code};
            if (code == `SPC_CNT_OFF)
                spc_secs = 15'h0000;
            else if (code <= `SPC_CNT_SEC_MAX)
                spc_secs = wide * `SPC_STEP_SEC;
            else if (code <= `SPC_CNT_HALF_MAX)
                spc_secs = (wide - {7'h00, `SPC_CNT_SEC_MAX}) * `SPC_STEP_HALF_HR;
            else if (code == `SPC_CNT_21M)
                spc_secs = `SPC_SEC_21M;
            else if (code == `SPC_CNT_8H)
                spc_secs = `SPC_SEC_8H;
            else if (code == `SPC_CNT_21M15)
                spc_secs = `SPC_SEC_21M15;
            else
                spc_secs = 15'h0000;
        end
    endfunction

    // commands are refused while the motor changes speed
    function spc_busy;
        input [1:0] st;
        begin
            spc_busy = (st == ST_SPINDOWN) || (st == ST_SPINUP);
        end
    endfunction

    // ----------------------------------------------------------------
    // spindle status synchronisers
    // ----------------------------------------------------------------
    reg speed_meta;
    reg speed_sync;
    reg stop_meta;
    reg stop_sync;

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            speed_meta <= 1'b0;
            speed_sync <= 1'b0;
            stop_meta  <= 1'b0;
            stop_sync  <= 1'b0;
        end else begin
            speed_meta <= spindle_at_speed_in;
            speed_sync <= speed_meta;
            stop_meta  <= spindle_stopped_in;
            stop_sync  <= stop_meta;
        end
    end

    // ----------------------------------------------------------------
    // seconds tick
    // ----------------------------------------------------------------
    wire sec_tick;

    spc_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .tick_out (sec_tick)
    );

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    reg [1:0]              state;
    reg [1:0]              next_state;
    reg [7:0]              timeout_code;
    reg [`SPC_SECS_W-1:0]  remaining;
    reg                    done_pending;

    wire is_timed  = (cmd_opcode_in == `SPC_OP_STBY_A) ||
                     (cmd_opcode_in == `SPC_OP_STBY_B);
    wire is_now    = (cmd_opcode_in == `SPC_OP_STBY_NOW_A) ||
                     (cmd_opcode_in == `SPC_OP_STBY_NOW_B);
    wire can_take  = !spc_busy(state);
    wire take_cmd  = cmd_valid_in && can_take;
    wire is_abort  = is_timed && (cmd_count_in == `SPC_CNT_ABORT);
    wire go_stby   = take_cmd && (is_now || (is_timed && !is_abort));
    wire other_cmd = take_cmd && !is_timed && !is_now;
    wire access    = host_access_in || other_cmd;
    wire expire    = timer_enabled_out && (state == ST_IDLE) && sec_tick &&
                     (remaining == 15'h0001) && !access && !cmd_valid_in;
    wire enter     = go_stby || expire;

    // ----------------------------------------------------------------
    // power state machine
    // ----------------------------------------------------------------
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (enter)
                    next_state = stop_sync ? ST_STANDBY : ST_SPINDOWN;
            end
            ST_SPINDOWN: begin
                if (stop_sync)
                    next_state = ST_STANDBY;
            end
            ST_STANDBY: begin
                if (go_stby)
                    next_state = ST_STANDBY;
                else if (access)
                    next_state = ST_SPINUP;
            end
            ST_SPINUP: begin
                if (speed_sync)
                    next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // ----------------------------------------------------------------
    // spindle and power outputs
    // ----------------------------------------------------------------
    // the spindle request is dropped on entry, and the interface logic
    // refuses commands while the motor coasts down
    reg next_run;
    reg next_standby;
    reg next_standby_z;
    reg next_hold;

    always @* begin
        next_run       = (next_state == ST_IDLE) || (next_state == ST_SPINUP);
        next_standby   = (next_state == ST_STANDBY) && !epc_enable_in;
        next_standby_z = (next_state == ST_STANDBY) && epc_enable_in;
        next_hold      = (next_state == ST_SPINUP);
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            spindle_run_out <= 1'b1;
            standby_out     <= 1'b0;
            standby_z_out   <= 1'b0;
            host_hold_out   <= 1'b0;
        end else begin
            spindle_run_out <= next_run;
            standby_out     <= next_standby;
            standby_z_out   <= next_standby_z;
            host_hold_out   <= next_hold;
        end
    end

    // ----------------------------------------------------------------
    // timeout setting and countdown
    // ----------------------------------------------------------------
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            timeout_code      <= `SPC_CNT_OFF;
            timer_enabled_out <= 1'b0;
        end else if (go_stby && is_timed) begin
            timeout_code      <= cmd_count_in;
            timer_enabled_out <= (cmd_count_in != `SPC_CNT_OFF);
        end
        // immediate standby falls through and keeps both values
    end

    // the count is held full outside idle, so it only runs down from
    // the moment the drive is idle again
    wire [`SPC_SECS_W-1:0] full_interval = spc_secs(timeout_code);
    wire                   reload_count  = (state != ST_IDLE) || access || cmd_valid_in;
    wire                   count_step    = timer_enabled_out && sec_tick &&
                                           (remaining != 15'h0000);

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in)
            remaining <= 15'h0000;
        else if (reload_count)
            remaining <= full_interval;
        else if (count_step)
            remaining <= remaining - 1'b1;
    end

    // ----------------------------------------------------------------
    // completion and result registers
    // ----------------------------------------------------------------
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in)
            done_pending <= 1'b0;
        else if (go_stby && !stop_sync && state == ST_IDLE)
            done_pending <= 1'b1;
        else if (state == ST_SPINDOWN && stop_sync)
            done_pending <= 1'b0;
    end

    // a command finishes at once when the motor is already at rest or the
    // drive is already in standby; otherwise when the spin-down completes
    wire finish_now  = go_stby && (state == ST_STANDBY || stop_sync);
    wire finish_late = done_pending && (state == ST_SPINDOWN) && stop_sync;

    reg       next_done;
    reg [7:0] next_error_flags;
    reg [7:0] next_status_flags;

    always @* begin
        next_done         = 1'b0;
        next_error_flags  = command_error_flags;
        next_status_flags = device_status_flags;
        if (take_cmd && is_abort) begin
            next_done                      = 1'b1;
            next_error_flags               = `SPC_ERR_RESET;
            next_error_flags[`SPC_ERR_ABT] = 1'b1;
            next_status_flags              = `SPC_ST_RESET;
            next_status_flags[`SPC_ST_ERR] = 1'b1;
        end else if (finish_now || finish_late) begin
            next_done         = 1'b1;
            next_error_flags  = `SPC_ERR_RESET;
            next_status_flags = `SPC_ST_RESET;
        end else if (go_stby) begin
            // spin-down under way: report busy until the motor stops
            next_status_flags              = `SPC_ST_RESET;
            next_status_flags[`SPC_ST_BSY] = 1'b1;
            next_status_flags[`SPC_ST_DSC] = 1'b0;
        end else begin
            // busy follows the states in which commands are refused, so a
            // spin-down started by the timer reports busy as well
            next_status_flags[`SPC_ST_BSY] = spc_busy(next_state);
            next_status_flags[`SPC_ST_DSC] = !spc_busy(next_state);
        end
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmd_done_out        <= 1'b0;
            command_error_flags <= `SPC_ERR_RESET;
            device_status_flags <= `SPC_ST_RESET;
        end else begin
            cmd_done_out        <= next_done;
            command_error_flags <= next_error_flags;
            device_status_flags <= next_status_flags;
        end
    end

endmodule

// *** logic/spc_defs.vh ***
// constants for the standby power command timer
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

// --------------------------------------------------------------------
// command opcodes
// --------------------------------------------------------------------
`define SPC_OP_STBY_A      8'hE2
`define SPC_OP_STBY_B      8'h96
`define SPC_OP_STBY_NOW_A  8'hE0
`define SPC_OP_STBY_NOW_B  8'h94

// --------------------------------------------------------------------
// timeout count codes and their intervals in seconds
// --------------------------------------------------------------------
`define SPC_CNT_OFF        8'h00
`define SPC_CNT_SEC_MAX    8'hF0
`define SPC_CNT_HALF_MAX   8'hFB
`define SPC_CNT_21M        8'hFC
`define SPC_CNT_8H         8'hFD
`define SPC_CNT_ABORT      8'hFE
`define SPC_CNT_21M15      8'hFF
`define SPC_STEP_SEC       15'h0005
`define SPC_STEP_HALF_HR   15'h0708
`define SPC_SEC_21M        15'h04EC
`define SPC_SEC_8H         15'h7080
`define SPC_SEC_21M15      15'h04FB
`define SPC_SECS_W         15

// --------------------------------------------------------------------
// error and status flag positions, reset values
// --------------------------------------------------------------------
`define SPC_ERR_ABT        2
`define SPC_ST_BSY         7
`define SPC_ST_RDY         6
`define SPC_ST_DF          5
`define SPC_ST_DSC         4
`define SPC_ST_COR         2
`define SPC_ST_ERR         0
`define SPC_ERR_RESET      8'h00
`define SPC_ST_RESET       8'h50

// --------------------------------------------------------------------
// timing
// --------------------------------------------------------------------
`define SPC_CLK_HZ         25000000
`define SPC_TICK_MS        1000
`define SPC_TICK_CYCLES    25'h17D7840
`define SPC_TICK_W         25

`endif

// *** logic/spc_tick.v ***
// one-second tick generator for the power-down countdown
`timescale 1ns/1ps
`include "spc_defs.vh"

module spc_tick #(
    parameter [`SPC_TICK_W-1:0] TICK_CYCLES = `SPC_TICK_CYCLES
) (
    // clock and reset
    input  wire clk_in,
    input  wire rstn_in,
    // tick
    output reg  tick_out
);

    reg [`SPC_TICK_W-1:0] count;

    // free running; the first interval may be short by up to one tick
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count    <= {`SPC_TICK_W{1'b0}};
            tick_out <= 1'b0;
        end else if (count == TICK_CYCLES - 1'b1) begin
            count    <= {`SPC_TICK_W{1'b0}};
            tick_out <= 1'b1;
        end else begin
            count    <= count + 1'b1;
            tick_out <= 1'b0;
        end
    end

endmodule

// *** sim/spc_spindle_model.sv ***
// behavioural spindle motor for the standby power command timer bench
`timescale 1ns/1ps
module spc_spindle_model #(
    parameter int STOP_CYC = 5,
    parameter int UP_CYC   = 6
) (
    // clock
    input  wire logic clk_in,
    // drive command from the block
    input  wire logic run_in,
    // motor state back to the block
    output logic      at_speed_out,
    output logic      stopped_out
);
    logic [7:0] up   = 8'h00;
    logic [7:0] down = 8'h00;

    initial at_speed_out = 1'b1;
    initial stopped_out  = 1'b0;

    // the flag of the old state drops at once when the drive command flips and the other rises after the count, like a real motor that
    // leaves speed long before it reaches rest
    always @(posedge clk_in) begin
        if (run_in) begin
            stopped_out <= 1'b0;
            down        <= 8'h00;
            if (up < UP_CYC) up <= up + 8'h01;
            else at_speed_out <= 1'b1;
        end else begin
            at_speed_out <= 1'b0;
            up           <= 8'h00;
            if (down < STOP_CYC) down <= down + 8'h01;
            else stopped_out <= 1'b1;
        end
    end
endmodule

// *** sim/spc_top_asserts.sv ***
// concurrent checks on the ports of the standby power command timer
`timescale 1ns/1ps
`include "spc_defs.vh"
module spc_top_asserts #(
    parameter [`SPC_TICK_W-1:0] TICK_CYCLES = `SPC_TICK_CYCLES
) (
    input wire logic       clk_in,
    input wire logic       rstn_in,
    input wire logic       cmd_valid_in,
    input wire logic [7:0] cmd_opcode_in,
    input wire logic [7:0] cmd_count_in,
    input wire logic       host_access_in,
    input wire logic       epc_enable_in,
    input wire logic       spindle_at_speed_in,
    input wire logic       spindle_stopped_in,
    input wire logic       spindle_run_out,
    input wire logic       standby_out,
    input wire logic       standby_z_out,
    input wire logic       host_hold_out,
    input wire logic       timer_enabled_out,
    input wire logic       cmd_done_out,
    input wire logic [7:0] command_error_flags,
    input wire logic [7:0] device_status_flags
);
    // a command is only taken while busy is clear
    wire timed = cmd_valid_in && !device_status_flags[7] &&
                 (cmd_opcode_in == `SPC_OP_STBY_A || cmd_opcode_in == `SPC_OP_STBY_B);
    wire immed = cmd_valid_in && !device_status_flags[7] &&
                 (cmd_opcode_in == `SPC_OP_STBY_NOW_A || cmd_opcode_in == `SPC_OP_STBY_NOW_B);

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    // --------------------------------------------------------------------
    // multi-step behaviours
    // --------------------------------------------------------------------
    // four samples cover the two-flop synchroniser plus the state register
    sequence at_speed_seen;
        host_hold_out ##0 spindle_at_speed_in [*4];
    endsequence
    sequence already_stopped;
        spindle_stopped_in [*3] ##0 immed;
    endsequence

    abort_resp_a: assert property (timed && cmd_count_in == 8'hFE |=> cmd_done_out &&
        command_error_flags == 8'h04 && device_status_flags == 8'h51)
        else $error("abort code gave wrong result");
    timer_load_a: assert property (timed && cmd_count_in != 8'hFE |=>
        timer_enabled_out == ($past(cmd_count_in) != 8'h00))
        else $error("timer enable not loaded from count");
    timer_keep_a: assert property (immed |=> $stable(timer_enabled_out))
        else $error("immediate standby changed timer enable");
    spin_stop_a: assert property ((timed && cmd_count_in != 8'hFE || immed) &&
        !standby_out && !standby_z_out |=> !spindle_run_out)
        else $error("spindle not stopped by standby");
    z_select_a: assert property (standby_z_out |-> !standby_out && $past(epc_enable_in))
        else $error("deep standby without extended power");
    wake_up_a: assert property (standby_out && host_access_in |=>
        spindle_run_out && host_hold_out && !standby_out)
        else $error("access in standby did not spin up");
    hold_release_a: assert property (at_speed_seen |=> !host_hold_out)
        else $error("hold kept after spindle at speed");
    skip_spin_a: assert property (already_stopped |=> cmd_done_out)
        else $error("spin-down not skipped");
    done_clean_a: assert property (cmd_done_out && !command_error_flags[`SPC_ERR_ABT] |->
        device_status_flags == 8'h50 && command_error_flags == 8'h00)
        else $error("completion flags wrong");
    done_pulse_a: assert property (cmd_done_out |=> !cmd_done_out)
        else $error("done longer than one cycle");
endmodule

bind spc_top spc_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_asserts (
    .clk_in(clk_in), .rstn_in(rstn_in), .cmd_valid_in(cmd_valid_in),
    .cmd_opcode_in(cmd_opcode_in), .cmd_count_in(cmd_count_in),
    .host_access_in(host_access_in), .epc_enable_in(epc_enable_in),
    .spindle_at_speed_in(spindle_at_speed_in), .spindle_stopped_in(spindle_stopped_in),
    .spindle_run_out(spindle_run_out), .standby_out(standby_out),
    .standby_z_out(standby_z_out), .host_hold_out(host_hold_out),
    .timer_enabled_out(timer_enabled_out), .cmd_done_out(cmd_done_out),
    .command_error_flags(command_error_flags), .device_status_flags(device_status_flags));

// *** sim/testbench.sv ***
// self-checking bench for the standby power command timer
`timescale 1ns/1ps
`include "spc_defs.vh"
module testbench;
    logic       clk_in = 1'b0, rstn_in = 1'b0, cmd_valid_in = 1'b0;
    logic       host_access_in = 1'b0, epc_enable_in = 1'b0;
    logic [7:0] cmd_opcode_in = 8'h00, cmd_count_in = 8'h00;
    wire        at_speed, stopped, run, sb, sbz, hold, ten, done;
    wire  [7:0] err, st;
    int         n_errors = 0, checks_done = 0, lat;
    logic [7:0] codes [5] = '{8'h01, 8'hF0, 8'hF1, 8'hFC, 8'hFF};

    always #20 clk_in = ~clk_in;

    // ten cycles a second keeps the half-hour codes inside the run
    spc_top #(.TICK_CYCLES(25'h000000A)) DUT (
        .clk_in(clk_in), .rstn_in(rstn_in), .cmd_valid_in(cmd_valid_in),
        .cmd_opcode_in(cmd_opcode_in), .cmd_count_in(cmd_count_in),
        .host_access_in(host_access_in), .epc_enable_in(epc_enable_in),
        .spindle_at_speed_in(at_speed), .spindle_stopped_in(stopped),
        .spindle_run_out(run), .standby_out(sb), .standby_z_out(sbz), .host_hold_out(hold),
        .timer_enabled_out(ten), .cmd_done_out(done),
        .command_error_flags(err), .device_status_flags(st));
    spc_spindle_model #(.STOP_CYC(5), .UP_CYC(6)) u_spindle (
        .clk_in(clk_in), .run_in(run), .at_speed_out(at_speed), .stopped_out(stopped));

    // --------------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    function automatic int secs(input int c);
        if (c <= 240) return c * 5;
        if (c <= 251) return (c - 240) * 1800;
        if (c == 252) return 1260;
        if (c == 253) return 28800;
        return 1275;
    endfunction

    // lat counts cycles from the taking edge to the done pulse
    task automatic cmd(input logic [7:0] op, input logic [7:0] cnt);
        @(posedge clk_in);
        cmd_valid_in  <= 1'b1;
        cmd_opcode_in <= op;
        cmd_count_in  <= cnt;
        @(posedge clk_in);
        cmd_valid_in <= 1'b0;
        lat = 0;
        @(negedge clk_in);
        while (done !== 1'b1 && lat < 300) begin
            lat++;
            @(negedge clk_in);
        end
        check(done, 1'b1);
    endtask

    task automatic wake;
        logic seen_hold;
        int   k;
        seen_hold = 1'b0;
        k = 0;
        @(posedge clk_in);
        host_access_in <= 1'b1;
        @(posedge clk_in);
        host_access_in <= 1'b0;
        while (!(seen_hold && hold === 1'b0) && k < 200) begin
            @(negedge clk_in);
            if (hold === 1'b1) seen_hold = 1'b1;
            k++;
        end
        check(seen_hold, 1'b1);
        check({sb, sbz, run}, 3'h1);
        check(st, 8'h50);
    endtask

    // free-running tick lets the first second come up short by up to nine cycles
    task automatic auto_down(input logic [7:0] c, input bit reload);
        int k, exp;
        exp = secs(c) * 10;
        if (reload) begin
            repeat (30) @(posedge clk_in);
            host_access_in <= 1'b1;
            @(posedge clk_in);
            host_access_in <= 1'b0;
        end
        // expiry drops the spindle request; standby follows once the motor rests
        k = 0;
        while (run !== 1'b0 && k < exp + 50) begin
            @(negedge clk_in);
            k++;
        end
        check(k >= exp - 9 && k <= exp, 1'b1);
        k = 0;
        while (sb !== 1'b1 && k < 50) begin
            @(negedge clk_in);
            k++;
        end
        check(sb, 1'b1);
    endtask

    // --------------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(negedge clk_in);
        check({st, err}, 16'h5000);
        check({run, ten}, 2'h2);
        cmd(`SPC_OP_STBY_A, `SPC_CNT_ABORT);
        check({st, err}, 16'h5104);
        check({sb, ten, run}, 3'h1);
        for (int i = 0; i < 5; i++) begin
            cmd(i % 2 ? `SPC_OP_STBY_B : `SPC_OP_STBY_A, codes[i]);
            check({sb, run, ten}, 3'h5);
            check({st, err}, 16'h5000);
            // staying in standby past the interval must not start the count
            if (i == 0) repeat (80) @(posedge clk_in);
            wake;
            auto_down(codes[i], i == 0);
        end
        // the eight-hour code must outlast 1300 s, longer than the 21-minute codes of the table
        cmd(`SPC_OP_STBY_A, `SPC_CNT_8H);
        check(ten, 1'b1);
        wake;
        repeat (13000) @(posedge clk_in);
        check({run, sb}, 2'h2);
        @(posedge clk_in);
        epc_enable_in <= 1'b1;
        cmd(`SPC_OP_STBY_NOW_A, 8'h00);
        check({sbz, sb, ten, run}, 4'hA);
        cmd(`SPC_OP_STBY_NOW_B, 8'h00);
        check(lat[7:0], 8'h00);
        check({sbz, ten}, 2'h3);
        cmd(`SPC_OP_STBY_B, `SPC_CNT_OFF);
        check({sbz, ten}, 2'h2);
        @(posedge clk_in);
        epc_enable_in <= 1'b0;
        wake;
        end_of_test;
    end

    initial begin
        #3200000;
        n_errors++;
        end_of_test;
    end
endmodule
